// ---- rtl/ivm_mapper.sv ----
// Interrupt vector mapper: masking, priority, vector address and reset address
`timescale 1ns/10ps

// What this block does
// R1: Converter-complete goes to vector 29 at 0x003A, EEPROM-ready to 30 at 0x003C.
// R2: Timer 3 capture, compares A-C, overflow use vectors 31-35 at 0x003E-0x0046.
// R3: Second serial port receive, empty, transmit use vectors 36-38 at 0x0048-0x004C.
// R4: Two-wire request is vector 39 at 0x004E, store-ready vector 40 at 0x0050.
// R5: Timer 4 capture, compares, overflow use vectors 41-45 at 0x0052-0x005A.
// R6: Timer 5 capture, compares, overflow use vectors 46-50 at 0x005C-0x0064.
// R7: Radio lock, unlock, rx start, rx end, assess done use 57-61 at 0x0072-0x007A.
// R8: Frame match, transmit end, wakeup use vectors 62-64 at 0x007C-0x0080.
// R9: Symbol counter compares 1-3, overflow, backoff use 65-69 at 0x0082-0x008A.
// R10: Cipher, battery, tx start, filters 0-3 use 70-76 at 0x008C-0x0098.
// R11: Reset address is 0x0000 with fuse unprogrammed, else the boot start.
// R12: Table starts at 0x0002; with select bit set, boot start is added.
// R13: Vector base is independent of reset place; all four combinations legal.
// R14: Vectors are offered only when an enabled interrupt is actually taken.
// R15: Vector 0 is reset for every cause; 1-28 carry the older sources.
// R16: Lowest pending enabled vector wins; reserved vectors 51-56 never raised.
module ivm_mapper #(
    parameter logic [ivm_pkg::PC_W-1:0] BOOT_START = ivm_pkg::BOOT_START_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic boot_reset_fuse,
    input wire logic vector_select_bit,
    input wire logic globalIntEnable,
    input wire logic [ivm_pkg::VEC_LAST:1] irqRequest,
    input wire logic [ivm_pkg::VEC_LAST:1] irqEnable,
    input wire logic cpuIntAck,
    output logic cpuIntReq,
    output ivm_pkg::ivm_fetch_t fetch,
    output logic [ivm_pkg::PC_W-1:0] cpuResetAddr,
    output logic [ivm_pkg::VEC_LAST:1] irqTaken
);
    import ivm_pkg::*;

    ivm_state_t state;
    ivm_state_t next_state;
    ivm_fetch_t next_fetch;
    logic [PC_W-1:0] next_cpuResetAddr;
    logic [VEC_LAST:1] next_irqTaken;
    logic [VEC_LAST:0] maskedReq;
    logic [VEC_W-1:0] winner;
    logic anyReq;
    logic [PC_W-1:0] base;

    // Per-vector gating; reserved slots and vector 0 are tied off
    assign maskedReq[VEC_RESET] = 1'b0; // see R15
    genvar gi;
    generate
        for (gi = 1; gi <= VEC_LAST; gi++) begin : g_mask
            if (gi >= RSV_FIRST && gi <= RSV_LAST) begin : g_rsv
                assign maskedReq[gi] = 1'b0; // see R16
            end else begin : g_src
                assign maskedReq[gi] = irqRequest[gi] & irqEnable[gi]; // see R14
            end
        end
    endgenerate

    // Fixed priority: scan down so the lowest number is left standing
    // A lowest-bit trick would be smaller; the loop reads more plainly
    always_comb begin
        winner = '0;
        for (int i = VEC_LAST; i >= 1; i--) begin
            if (maskedReq[i]) begin
                winner = VEC_W'(i); // see R16
            end
        end
    end

    assign anyReq = globalIntEnable & (|maskedReq);

    // Table base follows the select bit, not the fuse
    assign base = vector_select_bit ? BOOT_START : APP_RESET_ADDR; // see R12, R13

    // Offer sequencing and vector address generation
    always_comb begin
        next_state = state;
        next_fetch = fetch;
        next_irqTaken = '0;
        unique case (state)
            IVM_IDLE: begin
                if (anyReq) begin
                    // Address is vector number times two words plus base
                    next_state = IVM_OFFER; // see R14
                    next_fetch.valid = 1'b1;
                    next_fetch.boot = vector_select_bit;
                    next_fetch.num = winner;
                    next_fetch.addr = base + PC_W'({winner, 1'b0}); // see R1, R2, R3
                    // Same step covers every later source too; see R4, R5, R6
                    // see R7, R8, R9, R10
                end
            end
            IVM_OFFER: begin
                // Committed once offered; a late mask change cannot retract it
                if (cpuIntAck) begin
                    next_state = IVM_IDLE;
                    next_fetch.valid = 1'b0;
                    next_irqTaken[fetch.num] = 1'b1;
                end
            end
        endcase
    end

    // Offer registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= IVM_IDLE;
            fetch <= '0;
            irqTaken <= '0;
        end else begin
            state <= next_state;
            fetch <= next_fetch;
            irqTaken <= next_irqTaken;
        end
    end

    assign cpuIntReq = fetch.valid;

    // Reset address, caught from the fuse while reset is held
    always_comb begin
        next_cpuResetAddr = cpuResetAddr;
        if (sys_rst) begin
            next_cpuResetAddr = boot_reset_fuse ? APP_RESET_ADDR : BOOT_START; // see R11
        end
    end

    // Fuse changes after release are ignored until the next reset
    always_ff @(posedge clk) begin
        cpuResetAddr <= next_cpuResetAddr;
    end

    // Helper: offset of the offered vector from its table base
    // lowBit isolates the lowest pending bit, a second view of priority
    logic [PC_W-1:0] vecOff;
    logic [VEC_LAST:0] lowBit;
    assign vecOff = fetch.addr - (fetch.boot ? BOOT_START : APP_RESET_ADDR);
    assign lowBit = maskedReq & (~maskedReq + 77'h0_0000_0000_0000_0000_0001);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    convVec_a: assert property ( // see R1
        fetch.valid && fetch.num == VEC_CONVERTER |-> vecOff == ADDR_CONVERTER)
        else $error("converter vector address wrong");

    eepromVec_a: assert property ( // see R1
        fetch.valid && fetch.num == VEC_EEPROM |-> vecOff == ADDR_EEPROM)
        else $error("eeprom vector address wrong");

    timer3Vec_a: assert property ( // see R2
        fetch.valid && fetch.num >= VEC_TIMER3_FIRST && fetch.num <= VEC_TIMER3_LAST
        |-> vecOff == ADDR_TIMER3 + PC_W'({fetch.num - VEC_W'(VEC_TIMER3_FIRST), 1'b0}))
        else $error("timer 3 vector address wrong");

    radioVec_a: assert property ( // see R7
        fetch.valid && fetch.num >= VEC_RADIO_FIRST && fetch.num <= VEC_RADIO_LAST
        |-> vecOff == ADDR_RADIO + PC_W'({fetch.num - VEC_W'(VEC_RADIO_FIRST), 1'b0}))
        else $error("radio vector address wrong");

    filterVec_a: assert property ( // see R10
        fetch.valid && fetch.num == VEC_FILTER3 |-> vecOff == ADDR_FILTER3)
        else $error("filter 3 vector address wrong");

    resetAddr_a: assert property ( // see R11
        $fell(sys_rst) |-> cpuResetAddr ==
            ($past(boot_reset_fuse) ? APP_RESET_ADDR : BOOT_START))
        else $error("reset address does not follow fuse");

    vecBase_a: assert property ( // see R12
        $rose(fetch.valid) |-> fetch.addr ==
            ($past(vector_select_bit) ? BOOT_START : APP_RESET_ADDR)
            + PC_W'({fetch.num, 1'b0}))
        else $error("vector base does not follow select bit");

    onlyTaken_a: assert property ( // see R14
        $rose(fetch.valid) |-> $past(anyReq))
        else $error("vector offered without enabled request");

    lowestWins_a: assert property ( // see R16
        $rose(fetch.valid) |-> $past(lowBit) == (77'h1 << fetch.num))
        else $error("offered vector is not the lowest pending");

    noReserved_a: assert property ( // see R16
        fetch.valid |-> !(fetch.num inside {[RSV_FIRST:RSV_LAST]}) && fetch.num != 0)
        else $error("reserved or reset vector offered");

    takenPulse_a: assert property ( // see R14
        fetch.valid && cpuIntAck |=> irqTaken == (76'h1 << ($past(fetch.num) - 1))
        ##1 irqTaken == '0)
        else $error("taken pulse wrong");

    holdOffer_a: assert property ( // see R14
        fetch.valid && !cpuIntAck |=> fetch.valid && $stable(fetch.addr))
        else $error("offer dropped before acknowledge");

    // Remaining source groups, each against its own table entry
    serialVec_a: assert property ( // see R3
        fetch.valid && fetch.num >= VEC_SERIAL1_RX && fetch.num <= VEC_SERIAL1_LAST
        |-> vecOff == ADDR_SERIAL1 + PC_W'({fetch.num - VEC_W'(VEC_SERIAL1_RX), 1'b0}))
        else $error("second serial port vector address wrong");

    twoWireVec_a: assert property ( // see R4
        fetch.valid && fetch.num == VEC_TWO_WIRE |-> vecOff == ADDR_TWO_WIRE)
        else $error("two-wire vector address wrong");

    storeVec_a: assert property ( // see R4
        fetch.valid && fetch.num == VEC_PROG_STORE |-> vecOff == ADDR_PROG_STORE)
        else $error("store-ready vector address wrong");

    timer4Vec_a: assert property ( // see R5
        fetch.valid && fetch.num >= VEC_TIMER4_FIRST && fetch.num <= VEC_TIMER4_LAST
        |-> vecOff == ADDR_TIMER4 + PC_W'({fetch.num - VEC_W'(VEC_TIMER4_FIRST), 1'b0}))
        else $error("timer 4 vector address wrong");

    timer5Vec_a: assert property ( // see R6
        fetch.valid && fetch.num >= VEC_TIMER5_FIRST && fetch.num <= VEC_TIMER5_LAST
        |-> vecOff == ADDR_TIMER5 + PC_W'({fetch.num - VEC_W'(VEC_TIMER5_FIRST), 1'b0}))
        else $error("timer 5 vector address wrong");

    frameVec_a: assert property ( // see R8
        fetch.valid && fetch.num >= VEC_FRAME_MATCH && fetch.num <= VEC_FRAME_LAST
        |-> vecOff == ADDR_FRAME_MATCH + PC_W'({fetch.num - VEC_W'(VEC_FRAME_MATCH), 1'b0}))
        else $error("frame match group vector address wrong");

    symbolVec_a: assert property ( // see R9
        fetch.valid && fetch.num >= VEC_SYMBOL_FIRST && fetch.num <= VEC_SYMBOL_LAST
        |-> vecOff == ADDR_SYMBOL + PC_W'({fetch.num - VEC_W'(VEC_SYMBOL_FIRST), 1'b0}))
        else $error("symbol counter vector address wrong");

    cipherVec_a: assert property ( // see R10
        fetch.valid && fetch.num >= VEC_CIPHER && fetch.num <= VEC_FILTER3
        |-> vecOff == ADDR_CIPHER + PC_W'({fetch.num - VEC_W'(VEC_CIPHER), 1'b0}))
        else $error("cipher group vector address wrong");

    // Older sources below the named groups share the same two-word spacing
    oldVec_a: assert property ( // see R15
        fetch.valid && fetch.num >= VEC_FIRST_SRC && fetch.num <= VEC_OLD_LAST
        |-> vecOff == ADDR_TABLE + PC_W'({fetch.num - VEC_W'(VEC_FIRST_SRC), 1'b0}))
        else $error("older source vector address wrong");

    // Reset address is frozen between resets; outputs leave reset clean
    resetHold_a: assert property ( // see R11
        !$fell(sys_rst) |-> $stable(cpuResetAddr))
        else $error("reset address moved outside reset");

    resetClear_a: assert property ( // see R14
        $fell(sys_rst) |-> !fetch.valid && irqTaken == '0)
        else $error("offer or taken pulse left over from reset");

    // Offer handshake: one cycle to offer, one cycle to drop after the ack
    offerDelay_a: assert property ( // see R14
        !fetch.valid && anyReq |=> fetch.valid)
        else $error("enabled request not offered next cycle");

    dropOnAck_a: assert property ( // see R14
        fetch.valid && cpuIntAck |=> !fetch.valid)
        else $error("offer still up after acknowledge");

    idleStay_a: assert property ( // see R14
        !fetch.valid && !anyReq |=> !fetch.valid)
        else $error("offer raised with nothing pending");

    gieGate_a: assert property ( // see R14
        !globalIntEnable && !fetch.valid |=> !fetch.valid)
        else $error("offer raised while globally masked");

    // Taken pulse is the only word that tells a source to drop its level
    strayAck_a: assert property ( // see R14
        !fetch.valid |=> irqTaken == '0)
        else $error("taken pulse without an offer");

    takenOneHot_a: assert property ( // see R16
        $onehot0(irqTaken))
        else $error("more than one source taken at once");

    numStable_a: assert property ( // see R14
        fetch.valid && !cpuIntAck |=> $stable(fetch.num) && $stable(fetch.boot))
        else $error("offered vector changed before acknowledge");

    bootFlag_a: assert property ( // see R12
        $rose(fetch.valid) |-> fetch.boot == $past(vector_select_bit))
        else $error("base flag does not follow select bit");

    numRange_a: assert property ( // see R16
        fetch.valid |-> fetch.num <= VEC_LAST)
        else $error("vector number beyond the table");

    // Main scenarios the bench is expected to reach
    bootBase_c: cover property (
        $rose(fetch.valid) && fetch.boot && cpuResetAddr == APP_RESET_ADDR);
    twoPending_c: cover property (
        $rose(fetch.valid) && $countones($past(maskedReq)) > 1);
    backToBack_c: cover property (
        fetch.valid && cpuIntAck ##2 fetch.valid);
    filterTaken_c: cover property (
        fetch.valid && fetch.num == VEC_FILTER3 && cpuIntAck);
    appBase_c: cover property (
        $rose(fetch.valid) && !fetch.boot && cpuResetAddr == BOOT_START);

endmodule

// ---- rtl/ivm_pkg.sv ----
// Constants and types for the interrupt vector mapper
package ivm_pkg;

    // Widths
    localparam int PC_W = 17;
    localparam int VEC_W = 7;

    // Vector numbering
    localparam int VEC_RESET = 0;
    localparam int VEC_LAST = 76;
    localparam int RSV_FIRST = 51;
    localparam int RSV_LAST = 56;

    // Named sources inside the table
    localparam int VEC_CONVERTER = 29;
    localparam int VEC_EEPROM = 30;
    localparam int VEC_TIMER3_FIRST = 31;
    localparam int VEC_TIMER3_LAST = 35;
    localparam int VEC_SERIAL1_RX = 36;
    localparam int VEC_TWO_WIRE = 39;
    localparam int VEC_PROG_STORE = 40;
    localparam int VEC_TIMER4_FIRST = 41;
    localparam int VEC_TIMER5_FIRST = 46;
    localparam int VEC_RADIO_FIRST = 57;
    localparam int VEC_RADIO_LAST = 61;
    localparam int VEC_FRAME_MATCH = 62;
    localparam int VEC_SYMBOL_FIRST = 65;
    localparam int VEC_CIPHER = 70;
    localparam int VEC_FILTER3 = 76;
    localparam int VEC_SERIAL1_LAST = 38;
    localparam int VEC_TIMER4_LAST = 45;
    localparam int VEC_TIMER5_LAST = 50;
    localparam int VEC_FRAME_LAST = 64;
    localparam int VEC_SYMBOL_LAST = 69;
    localparam int VEC_FIRST_SRC = 1;
    localparam int VEC_OLD_LAST = 28;

    // Word offsets from the table base
    localparam logic [PC_W-1:0] APP_RESET_ADDR = 17'h0_0000;
    localparam logic [PC_W-1:0] ADDR_CONVERTER = 17'h0_003A;
    localparam logic [PC_W-1:0] ADDR_EEPROM = 17'h0_003C;
    localparam logic [PC_W-1:0] ADDR_TIMER3 = 17'h0_003E;
    localparam logic [PC_W-1:0] ADDR_RADIO = 17'h0_0072;
    localparam logic [PC_W-1:0] ADDR_FILTER3 = 17'h0_0098;
    localparam logic [PC_W-1:0] ADDR_TABLE = 17'h0_0002;
    localparam logic [PC_W-1:0] ADDR_SERIAL1 = 17'h0_0048;
    localparam logic [PC_W-1:0] ADDR_TWO_WIRE = 17'h0_004E;
    localparam logic [PC_W-1:0] ADDR_PROG_STORE = 17'h0_0050;
    localparam logic [PC_W-1:0] ADDR_TIMER4 = 17'h0_0052;
    localparam logic [PC_W-1:0] ADDR_TIMER5 = 17'h0_005C;
    localparam logic [PC_W-1:0] ADDR_FRAME_MATCH = 17'h0_007C;
    localparam logic [PC_W-1:0] ADDR_SYMBOL = 17'h0_0082;
    localparam logic [PC_W-1:0] ADDR_CIPHER = 17'h0_008C;

    // Reset value of the default boot section start
    localparam logic [PC_W-1:0] BOOT_START_DEF = 17'h1_F000;

    // Offer handshake states
    typedef enum logic {
        IVM_IDLE,
        IVM_OFFER
    } ivm_state_t;

    // Vector offered to the CPU fetch unit
    typedef struct packed {
        logic valid;
        logic boot;
        logic [VEC_W-1:0] num;
        logic [PC_W-1:0] addr;
    } ivm_fetch_t;

endpackage

// ---- tb/ivm_cpu_model.sv ----
// CPU fetch unit model that takes offered vectors after a set wait
`timescale 1ns/10ps
module ivm_cpu_model (
    input wire logic clk,
    input wire logic cpuIntReq,
    input wire logic [3:0] ackWait,
    output logic cpuIntAck
);
    int waitCnt = 0;
    logic ackReg = 1'b0;
    assign cpuIntAck = ackReg;
    // Ack is held until the rising edge that samples it, then released
    always @(negedge clk) begin
        if (!cpuIntReq || ackReg) begin
            ackReg <= 1'b0;
            waitCnt <= 0;
        end else if (waitCnt >= ackWait) begin
            ackReg <= 1'b1;
        end else begin
            waitCnt <= waitCnt + 1;
        end
    end
endmodule

// ---- tb/ivm_mapper_tb.sv ----
// Self-checking testbench for the interrupt vector mapper
`timescale 1ns/10ps
module ivm_mapper_tb;
    import ivm_pkg::*;
    // Non-default boot start, so a stuck default would show
    localparam logic [PC_W-1:0] BS = 17'h1_E000;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic fuse = 1'b1;
    logic vsel = 1'b0;
    logic gie = 1'b0;
    logic [VEC_LAST:1] irqRequest = '0;
    logic [VEC_LAST:1] irqEnable = '0;
    logic [VEC_LAST:1] irqTaken;
    logic cpuIntAck;
    logic cpuIntReq;
    ivm_fetch_t fetch;
    logic [PC_W-1:0] cpuResetAddr;
    logic [3:0] ackWait = 4'h2;
    int errorCnt = 0;
    int testsRun = 0;
    always #20 clk = ~clk;
    ivm_mapper #(.BOOT_START(BS)) ivm_mapper_i (.clk(clk), .sys_rst(sysRst),
        .boot_reset_fuse(fuse), .vector_select_bit(vsel), .globalIntEnable(gie),
        .irqRequest(irqRequest), .irqEnable(irqEnable), .cpuIntAck(cpuIntAck),
        .cpuIntReq(cpuIntReq), .fetch(fetch), .cpuResetAddr(cpuResetAddr),
        .irqTaken(irqTaken));
    ivm_cpu_model ivm_cpu_model_i (.clk(clk), .cpuIntReq(cpuIntReq), .ackWait(ackWait),
        .cpuIntAck(cpuIntAck));
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        testsRun++;
        if (seen !== expd) begin
            errorCnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic finalReport();
        $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Reset with a given fuse; fuse moves after release must not matter
    task automatic reset_test(input logic f);
        fuse = f;
        sysRst = 1'b1;
        repeat (20) @(negedge clk);
        sysRst = 1'b0;
        fuse = ~f;
        repeat (2) @(negedge clk);
        check(cpuResetAddr, f ? 17'h0_0000 : BS);
        check(cpuIntReq, 1'b0);
        $display("reset test done");
    endtask
    // Wait for an offer, judge it, flip the select bit, then wait for the taken pulse
    task automatic serve(input int n, input logic vs);
        int k;
        for (k = 0; k < 10 && cpuIntReq !== 1'b1; k++) @(negedge clk);
        check(fetch.num, n);
        check(fetch.addr, (vs ? BS : 17'h0_0000) + 17'(2 * n));
        check(fetch.boot, vs);
        vsel = ~vs;
        @(negedge clk);
        check(fetch.addr, (vs ? BS : 17'h0_0000) + 17'(2 * n));
        vsel = vs;
        for (k = 0; k < 10 && irqTaken === '0; k++) @(negedge clk);
        check(32'(irqTaken === (76'(1) << (n - 1))), 1);
        irqRequest[n] = 1'b0;
    endtask
    // Every live vector with both table bases
    task automatic table_test();
        for (int v = 0; v < 2; v++) begin
            for (int n = 1; n <= VEC_LAST; n++) begin
                if (n < RSV_FIRST || n > RSV_LAST) begin
                    vsel = v[0];
                    irqRequest[n] = 1'b1;
                    serve(n, v[0]);
                    @(negedge clk);
                end
            end
        end
        $display("table test done");
    endtask
    // Nothing may be on offer at the end of eight cycles
    task automatic quiet();
        repeat (8) @(negedge clk);
        check(cpuIntReq, 1'b0);
    endtask
    // Reserved, disabled and globally masked requests stay silent
    task automatic refuse_test();
        irqRequest[RSV_LAST:RSV_FIRST] = '1;
        quiet();
        irqRequest = '0;
        irqEnable[30] = 1'b0;
        irqRequest[30] = 1'b1;
        quiet();
        irqEnable[30] = 1'b1;
        gie = 1'b0;
        quiet();
        gie = 1'b1;
        vsel = 1'b0;
        serve(30, 1'b0);
        $display("refuse test done");
    endtask
    // Several pending at once, lowest number first
    task automatic priority_test();
        vsel = 1'b1;
        ackWait = 4'h0;
        irqRequest[76] = 1'b1;
        irqRequest[57] = 1'b1;
        irqRequest[40] = 1'b1;
        irqRequest[29] = 1'b1;
        serve(29, 1'b1);
        serve(40, 1'b1);
        serve(57, 1'b1);
        serve(76, 1'b1);
        $display("priority test done");
    endtask
    // Reset in the boot area with vectors in either area
    task automatic placement_test();
        reset_test(1'b0);
        for (int v = 0; v < 2; v++) begin
            vsel = v[0];
            irqRequest[VEC_EEPROM] = 1'b1;
            serve(VEC_EEPROM, v[0]);
            check(cpuResetAddr, BS);
            @(negedge clk);
        end
        $display("placement test done");
    endtask
    // Run length is a few thousand cycles at most
    initial begin
        #(6000 * 40);
        errorCnt++;
        finalReport();
    end
    initial begin
        reset_test(1'b0);
        reset_test(1'b1);
        gie = 1'b1;
        irqEnable = '1;
        table_test();
        refuse_test();
        priority_test();
        placement_test();
        finalReport();
    end
endmodule
